// file: logic/dmt_exec.sv
// multiply, accumulate and register transfer execution unit with axi4-lite
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
module dmt_exec
   import dmt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // write address channel
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   // write data channel
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   // write response channel
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // read address channel
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   // read data channel
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);

   function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                         logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = n[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // guard bits disagreeing with bit 31 means the 32-bit range was left
   function automatic logic ovf(logic [39:0] a);
      return !((&a[39:31]) || !(|a[39:31]));
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // state
   logic awh_r, awh_nxt, wh_r, wh_nxt, awrdy_r, awrdy_nxt;
   logic wrdy_r, wrdy_nxt, bvalid_r, bvalid_nxt, arrdy_r, arrdy_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [7:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   dmt_state_e st_r, st_nxt;
   dmt_cmd_s cmd_r, cmd_nxt, wcmd;
   logic [15:0] lit_r, lit_nxt;
   logic [15:0] w_r [16];
   logic [15:0] w_nxt [16];
   logic [15:0] f_r [16];
   logic [15:0] f_nxt [16];
   logic [39:0] acca_r, acca_nxt, accb_r, accb_nxt;
   logic ova_r, ova_nxt, ovb_r, ovb_nxt, cla_r, cla_nxt, clb_r, clb_nxt;
   logic [9:0] rdpag_r, rdpag_nxt;
   logic [8:0] wrpag_r, wrpag_nxt;
   logic [7:0] tbpag_r, tbpag_nxt;

   //////////////////////////////////////////////////////////////////////////
   // decode and datapath
   logic fire, werr, go, upd, rerr;
   logic [7:0] wa, ra;
   logic [31:0] rd_val, wm;
   logic [15:0] opa, opb;
   logic signed [31:0] prod;
   logic [39:0] pext, accv, base, addend, other;
   logic [40:0] sum41;
   logic [3:0] ev_s, ev_d;

   assign wa = {waddr_r[7:2], 2'b00};
   assign ra = {s_araddr[7:2], 2'b00};
   assign fire = awh_r && wh_r && !bvalid_r;
   assign wcmd = dmt_cmd_s'(wdata_r[CMD_W-1:0]);
   assign opa = w_r[cmd_r.srca];
   assign opb = cmd_r.sq ? opa : w_r[cmd_r.srcb];
   assign prod = $signed(opa) * $signed(opb);
   assign pext = {{8{prod[31]}}, prod};
   assign accv = cmd_r.acc ? accb_r : acca_r;
   assign other = cmd_r.acc ? acca_r : accb_r;
   assign base = (cmd_r.op == OP_MULACC || cmd_r.op == OP_MSUB) ? accv : '0;
   assign addend = (cmd_r.op == OP_MSUB) ? -pext : pext;
   assign sum41 = {base[39], base} + {addend[39], addend};
   assign ev_s = {cmd_r.srca[3:1], 1'b0};
   assign ev_d = {cmd_r.dst[3:1], 1'b0};
   assign upd = st_r == ST_EXEC && (cmd_r.op == OP_MULACC ||
                cmd_r.op == OP_MUL || cmd_r.op == OP_MSUB);
   assign wm = merge(wa[7:6] == A_WREGION ? {16'h0000, w_r[wa[5:2]]} :
                     {16'h0000, f_r[wa[5:2]]}, wdata_r, wstrb_r);

   // command, page and array writes are refused while an op is running
   always_comb begin
      werr = 1'b0;
      go = 1'b0;
      if (wa == A_LIT) begin
         werr = 1'b0;
      end else if (wa == A_CMD || wa == A_PAGE || wa[7:6] == A_WREGION ||
                   wa[7:6] == A_FREGION) begin
         werr = st_r != ST_IDLE;
         go = fire && wa == A_CMD && st_r == ST_IDLE;
      end else begin
         werr = 1'b1;
      end
   end

   always_comb begin
      rerr = 1'b0;
      rd_val = 32'h0000_0000;
      case (ra)
         A_CMD: rd_val = 32'(cmd_r);
         A_LIT: rd_val = {16'h0000, lit_r};
         A_STAT: rd_val = {25'h0, clb_r, cla_r, cla_r || clb_r, ovb_r,
                           ova_r, ova_r || ovb_r, st_r != ST_IDLE};
         A_ACCA_LO: rd_val = acca_r[31:0];
         A_ACCA_HI: rd_val = {24'h0, acca_r[39:32]};
         A_ACCB_LO: rd_val = accb_r[31:0];
         A_ACCB_HI: rd_val = {24'h0, accb_r[39:32]};
         A_PAGE: rd_val = {5'h00, tbpag_r, wrpag_r, rdpag_r};
         default: begin
            if (ra[7:6] == A_WREGION) begin
               rd_val = {16'h0000, w_r[ra[5:2]]};
            end else if (ra[7:6] == A_FREGION) begin
               rd_val = {16'h0000, f_r[ra[5:2]]};
            end else begin
               rerr = 1'b1;
            end
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   always_comb begin
      awh_nxt = awh_r;
      wh_nxt = wh_r;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_awvalid && awrdy_r) begin
         awh_nxt = 1'b1;
         waddr_nxt = s_awaddr;
      end
      if (s_wvalid && wrdy_r) begin
         wh_nxt = 1'b1;
         wdata_nxt = s_wdata;
         wstrb_nxt = s_wstrb;
      end
      if (bvalid_r && s_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (fire) begin
         awh_nxt = 1'b0;
         wh_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = werr ? RESP_SLVERR : RESP_OK;
      end
      if (rvalid_r && s_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_arvalid && arrdy_r) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_val;
         rresp_nxt = rerr ? RESP_SLVERR : RESP_OK;
      end
      awrdy_nxt = !awh_nxt;
      wrdy_nxt = !wh_nxt;
      arrdy_nxt = !rvalid_nxt;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awh_r <= 1'b0;
         wh_r <= 1'b0;
         awrdy_r <= 1'b0;
         wrdy_r <= 1'b0;
         arrdy_r <= 1'b0;
         waddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OK;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OK;
      end else begin
         awh_r <= awh_nxt;
         wh_r <= wh_nxt;
         awrdy_r <= awrdy_nxt;
         wrdy_r <= wrdy_nxt;
         arrdy_r <= arrdy_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_awready = awrdy_r;
   assign s_wready = wrdy_r;
   assign s_bvalid = bvalid_r;
   assign s_bresp = bresp_r;
   assign s_arready = arrdy_r;
   assign s_rvalid = rvalid_r;
   assign s_rdata = rdata_r;
   assign s_rresp = rresp_r;

   //////////////////////////////////////////////////////////////////////////
   // execution
   always_comb begin
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      lit_nxt = lit_r;
      w_nxt = w_r;
      f_nxt = f_r;
      acca_nxt = acca_r;
      accb_nxt = accb_r;
      ova_nxt = ova_r;
      ovb_nxt = ovb_r;
      cla_nxt = cla_r;
      clb_nxt = clb_r;
      rdpag_nxt = rdpag_r;
      wrpag_nxt = wrpag_r;
      tbpag_nxt = tbpag_r;
      if (fire && !werr) begin
         if (wa == A_LIT) begin
            lit_nxt = 16'(merge({16'h0000, lit_r}, wdata_r, wstrb_r));
         end else if (wa == A_PAGE) begin
            rdpag_nxt = wdata_r[P_RD_LSB +: 10];
            wrpag_nxt = wdata_r[P_WR_LSB +: 9];
            tbpag_nxt = wdata_r[P_TB_LSB +: 8];
         end else if (wa[7:6] == A_WREGION) begin
            w_nxt[wa[5:2]] = wm[15:0];
         end else if (wa[7:6] == A_FREGION) begin
            f_nxt[wa[5:2]] = wm[15:0];
         end
      end
      case (st_r)
         ST_IDLE: begin
            if (go) begin
               cmd_nxt = wcmd;
               // peripheral target: one stall cycle first
               st_nxt = wcmd.periph ? ST_WAIT : ST_EXEC;
            end
         end
         ST_WAIT: st_nxt = ST_EXEC;
         ST_EXEC: begin
            st_nxt = ST_IDLE;
            case (cmd_r.op)
               OP_MULACC, OP_MUL, OP_MSUB: begin
                  if (cmd_r.acc) begin
                     accb_nxt = sum41[39:0];
                     clb_nxt = sum41[40] ^ sum41[39];
                  end else begin
                     acca_nxt = sum41[39:0];
                     cla_nxt = sum41[40] ^ sum41[39];
                  end
                  if (cmd_r.wback && cmd_r.op != OP_MUL) begin
                     w_nxt[WB_REG] = other[31:16];
                  end
               end
               OP_NMUL: begin
                  // flags deliberately left alone
                  if (cmd_r.acc) begin
                     accb_nxt = -pext;
                  end else begin
                     acca_nxt = -pext;
                  end
               end
               OP_PFST: begin
                  w_nxt[cmd_r.dst] = f_r[w_r[cmd_r.srca][3:0]];
                  if (cmd_r.wback) begin
                     w_nxt[WB_REG] = other[31:16];
                  end
               end
               OP_F2W: w_nxt[cmd_r.dst] = f_r[cmd_r.srca];
               OP_F2DW: w_nxt[DEF_WORK] = f_r[cmd_r.srca];
               OP_F2F: f_nxt[cmd_r.srca] = f_r[cmd_r.srca];
               OP_W2F: f_nxt[cmd_r.dst] = w_r[cmd_r.srca];
               OP_DW2F: f_nxt[cmd_r.dst] = w_r[DEF_WORK];
               OP_W2W: w_nxt[cmd_r.dst] = w_r[cmd_r.srca];
               OP_LIT16: w_nxt[cmd_r.dst] = lit_r;
               // byte form keeps the upper byte of the target
               OP_LIT8: w_nxt[cmd_r.dst][7:0] = lit_r[7:0];
               OP_DBL_OUT: begin
                  f_nxt[cmd_r.dst] = w_r[ev_s];
                  st_nxt = ST_SECOND;
               end
               OP_DBL_IN: begin
                  w_nxt[ev_d] = f_r[cmd_r.srca];
                  st_nxt = ST_SECOND;
               end
               OP_PL_RD: rdpag_nxt = lit_r[9:0];
               OP_PL_WR: wrpag_nxt = lit_r[8:0];
               OP_PL_TB: tbpag_nxt = lit_r[7:0];
               OP_PW_RD: rdpag_nxt = opa[9:0];
               OP_PW_WR: wrpag_nxt = opa[8:0];
               OP_PW_TB: tbpag_nxt = opa[7:0];
               default: st_nxt = ST_IDLE;
            endcase
         end
         ST_SECOND: begin
            st_nxt = ST_IDLE;
            if (cmd_r.op == OP_DBL_OUT) begin
               f_nxt[4'(cmd_r.dst + 4'h1)] = w_r[ev_s | 4'h1];
            end else begin
               w_nxt[ev_d | 4'h1] = f_r[4'(cmd_r.srca + 4'h1)];
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      if (upd) begin
         ova_nxt = ovf(acca_nxt);
         ovb_nxt = ovf(accb_nxt);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_IDLE;
         cmd_r <= '0;
         lit_r <= 16'h0000;
         acca_r <= 40'h00_0000_0000;
         accb_r <= 40'h00_0000_0000;
         ova_r <= 1'b0;
         ovb_r <= 1'b0;
         cla_r <= 1'b0;
         clb_r <= 1'b0;
         rdpag_r <= 10'h000;
         wrpag_r <= 9'h000;
         tbpag_r <= 8'h00;
         for (int i = 0; i < 16; i++) begin
            w_r[i] <= 16'h0000;
            f_r[i] <= 16'h0000;
         end
      end else begin
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         lit_r <= lit_nxt;
         acca_r <= acca_nxt;
         accb_r <= accb_nxt;
         ova_r <= ova_nxt;
         ovb_r <= ovb_nxt;
         cla_r <= cla_nxt;
         clb_r <= clb_nxt;
         rdpag_r <= rdpag_nxt;
         wrpag_r <= wrpag_nxt;
         tbpag_r <= tbpag_nxt;
         w_r <= w_nxt;
         f_r <= f_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic ex;
   assign ex = st_r == ST_EXEC;

   mul_result_a: assert property (ex && cmd_r.op == OP_MUL
      && !cmd_r.acc
      |=> acca_r == $past(pext) && ova_r == ovf(acca_r))
      else $error("multiply result wrong");
   square_a: assert property (ex && cmd_r.sq && cmd_r.op == OP_MUL
      |=> (cmd_r.acc ? accb_r : acca_r) ==
      40'($signed($past(opa)) * $signed($past(opa))))
      else $error("square result wrong");
   negmul_flags_a: assert property (ex && cmd_r.op == OP_NMUL
      |=> $stable({ova_r, ovb_r, cla_r, clb_r}) &&
      (cmd_r.acc ? accb_r : acca_r) == -$past(pext))
      else $error("negated multiply wrong");
   msub_result_a: assert property (ex && cmd_r.op == OP_MSUB
      |=> (cmd_r.acc ? accb_r : acca_r) ==
      40'($past(accv) - $past(pext)))
      else $error("multiply-subtract wrong");
   dbl_two_a: assert property (ex && (cmd_r.op == OP_DBL_IN ||
      cmd_r.op == OP_DBL_OUT) |=> st_r == ST_SECOND ##1 st_r == ST_IDLE)
      else $error("double move not two cycles");
   page_lit_a: assert property (ex && cmd_r.op == OP_PL_RD
      |=> rdpag_r == $past(lit_r[9:0]))
      else $error("read page literal wrong");
   page_reg_a: assert property (ex && cmd_r.op == OP_PW_TB
      |=> tbpag_r == $past(opa[7:0]))
      else $error("table page from w reg wrong");
   lit16_load_a: assert property (ex && cmd_r.op == OP_LIT16
      |=> w_r[cmd_r.dst] == lit_r && st_r == ST_IDLE)
      else $error("16-bit literal load wrong");
   periph_wait_a: assert property (st_r == ST_IDLE && go && wcmd.periph
      |=> st_r == ST_WAIT ##1 st_r == ST_EXEC)
      else $error("peripheral stall missing");
   xfer_flags_a: assert property (ex && cmd_r.op == OP_W2W
      |=> $stable({ova_r, ovb_r, cla_r, clb_r}) && st_r == ST_IDLE)
      else $error("word transfer disturbed flags");

   mulacc_cov: cover property (ex && cmd_r.op == OP_MULACC && cmd_r.wback);
   dbl_cov: cover property (st_r == ST_SECOND);
   periph_cov: cover property (st_r == ST_WAIT);
endmodule

// file: logic/dmt_pkg.sv
// shared constants and types for the multiply and transfer execution unit
package dmt_pkg;
   // register byte offsets and the address[7:6] codes of the w and f regions
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_LIT = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_ACCA_LO = 8'h0c;
   localparam logic [7:0] A_ACCA_HI = 8'h10;
   localparam logic [7:0] A_ACCB_LO = 8'h14;
   localparam logic [7:0] A_ACCB_HI = 8'h18;
   localparam logic [7:0] A_PAGE = 8'h1c;
   localparam logic [1:0] A_WREGION = 2'h1;
   localparam logic [1:0] A_FREGION = 2'h2;
   // page register field positions inside the page word
   localparam int P_RD_LSB = 0;
   localparam int P_WR_LSB = 10;
   localparam int P_TB_LSB = 19;
   // opcodes written into the command register
   localparam logic [4:0] OP_MULACC = 5'h01;
   localparam logic [4:0] OP_MUL = 5'h02;
   localparam logic [4:0] OP_NMUL = 5'h03;
   localparam logic [4:0] OP_MSUB = 5'h04;
   localparam logic [4:0] OP_PFST = 5'h05;
   localparam logic [4:0] OP_F2W = 5'h06;
   localparam logic [4:0] OP_F2F = 5'h07;
   localparam logic [4:0] OP_F2DW = 5'h08;
   localparam logic [4:0] OP_LIT16 = 5'h09;
   localparam logic [4:0] OP_LIT8 = 5'h0a;
   localparam logic [4:0] OP_W2F = 5'h0b;
   localparam logic [4:0] OP_W2W = 5'h0c;
   localparam logic [4:0] OP_DW2F = 5'h0d;
   localparam logic [4:0] OP_DBL_OUT = 5'h0e;
   localparam logic [4:0] OP_DBL_IN = 5'h0f;
   localparam logic [4:0] OP_PL_RD = 5'h10;
   localparam logic [4:0] OP_PL_WR = 5'h11;
   localparam logic [4:0] OP_PL_TB = 5'h12;
   localparam logic [4:0] OP_PW_RD = 5'h13;
   localparam logic [4:0] OP_PW_WR = 5'h14;
   localparam logic [4:0] OP_PW_TB = 5'h15;
   // misc
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [3:0] WB_REG = 4'hd;
   localparam logic [3:0] DEF_WORK = 4'h0;
   localparam int CMD_W = 21;
   typedef struct packed {
      logic sq;
      logic periph;
      logic wback;
      logic acc;
      logic [3:0] srcb;
      logic [3:0] srca;
      logic [3:0] dst;
      logic [4:0] op;
   } dmt_cmd_s;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_EXEC, ST_SECOND} dmt_state_e;
endpackage

// file: dv/dmt_prog_model.sv
// program memory model: instruction words with their literals
`timescale 1ns/100ps
module dmt_prog_model
   import dmt_pkg::*;
(
   // fetch address
   input wire logic [4:0] pc,
   // fetched instruction word and literal
   output dmt_cmd_s insn,
   output logic [31:0] lit
);
   // f packs square, periph, writeback and acc select, msb first
   function automatic dmt_cmd_s c(input logic [4:0] op,
         input logic [3:0] d = 4'h0, input logic [3:0] a = 4'h0,
         input logic [3:0] b = 4'h0, input logic [3:0] f = 4'h0);
      return {f, b, a, d, op};
   endfunction
   //////////////////////////////////////////////////
   always_comb begin
      lit = 32'hffff_ffff;
      insn = c(5'h00);
      case (pc)
         5'h00: {lit, insn} = {32'h8000, c(OP_LIT16, 4'h1)};
         5'h01: {lit, insn} = {32'h8000, c(OP_LIT16, 4'h2)};
         5'h02: {lit, insn} = {32'h0003, c(OP_LIT16, 4'h3)};
         5'h03: {lit, insn} = {32'hbeef, c(OP_LIT16, 4'h7)};
         5'h04: {lit, insn} = {32'h0005, c(OP_LIT16, 4'h4)};
         5'h05: insn = c(OP_W2F, 4'h5, 4'h7);
         5'h06: insn = c(OP_MUL, 4'h0, 4'h1, 4'h2);
         5'h07: insn = c(OP_MULACC, 4'h0, 4'h1, 4'h2, 4'h2);
         5'h08: insn = c(OP_NMUL, 4'h0, 4'h1, 4'h3, 4'h1);
         5'h09: insn = c(OP_PFST, 4'h6, 4'h4, 4'h0, 4'h3);
         5'h0a: insn = c(OP_MSUB, 4'h0, 4'h1, 4'h2, 4'h2);
         // square: srcb differs on purpose, must be ignored
         5'h0b: insn = c(OP_MUL, 4'h0, 4'h3, 4'h2, 4'h9);
         5'h0c: {lit, insn} = {32'h0001_2345, c(OP_LIT8, 4'h7)};
         5'h0d: insn = c(OP_W2W, 4'h8, 4'h7);
         5'h0e: insn = c(OP_F2DW, 4'h0, 4'h5);
         5'h0f: insn = c(OP_DW2F, 4'h9);
         5'h10: insn = c(OP_F2W, 4'h9, 4'h9);
         // odd source pair index must be rounded down to even
         5'h11: insn = c(OP_DBL_OUT, 4'ha, 4'h9);
         5'h12: insn = c(OP_DBL_IN, 4'hf, 4'ha, 4'h0, 4'h4);
         5'h13: insn = c(OP_PL_RD);
         5'h14: insn = c(OP_PL_WR);
         5'h15: insn = c(OP_PL_TB);
         5'h16: insn = c(OP_PW_RD, 4'h0, 4'h7);
         5'h17: insn = c(OP_PW_WR, 4'h0, 4'h7);
         5'h18: insn = c(OP_PW_TB, 4'h0, 4'h7, 4'h0, 4'h4);
         5'h19: insn = c(OP_F2F, 4'h0, 4'h9);
         default: ;
      endcase
   end
endmodule

// file: dv/tb_dsp_multiply_transfer_ops.sv
// self-checking bench for the multiply and transfer execution unit
`timescale 1ns/100ps
module tb_dsp_multiply_transfer_ops
   import dmt_pkg::*;
;
   logic clk, rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   logic [7:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, lit;
   logic [3:0] s_wstrb;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic [4:0] pc;
   dmt_cmd_s insn;
   int num_errors = 0;
   int tests_run = 0;

   dmt_exec dut (.clk(clk), .rst(rst), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
      .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready));
   dmt_prog_model prog (.pc(pc), .insn(insn), .lit(lit));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   //////////////////////////////////////////////////
   task automatic stop_test();
      if (num_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t data %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t resp %h expected %h", $time, got, exp);
      end
   endtask
   // ready channels stay high, so the answer edge is the handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= s;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      repeat (50) begin
         @(posedge clk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
         if (s_bvalid === 1'b1) begin
            chk_r(s_bresp, er);
            return;
         end
      end
      num_errors++;
      $display("CHECK FAILED t=%0t no write response", $time);
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er,
                     output logic [31:0] d);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      d = 32'h0;
      repeat (50) begin
         @(posedge clk);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
         if (s_rvalid === 1'b1) begin
            d = s_rdata;
            chk_r(s_rresp, er);
            return;
         end
      end
      num_errors++;
      $display("CHECK FAILED t=%0t no read response", $time);
   endtask
   task automatic rck(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, RESP_OK, d);
      chk_d(d, e);
   endtask
   task automatic idle();
      logic [31:0] d;
      repeat (20) begin
         rd(A_STAT, RESP_OK, d);
         if (d[0] === 1'b0) return;
      end
      num_errors++;
      $display("CHECK FAILED t=%0t busy stuck", $time);
   endtask
   // busy read straight after the response tells one cycle from more
   task automatic exec(input logic [4:0] p, input logic eb);
      logic [31:0] d;
      pc <= p;
      @(posedge clk);
      wr(A_LIT, lit, 4'hf, RESP_OK);
      wr(A_CMD, {11'h0, insn}, 4'hf, RESP_OK);
      rd(A_STAT, RESP_OK, d);
      chk_d({31'h0, d[0]}, {31'h0, eb});
      idle();
   endtask
   //////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] d;
      rck(A_STAT, 32'h0);
      rck(A_PAGE, 32'h0);
      rd(8'h20, RESP_SLVERR, d);
      wr(A_STAT, 32'h1, 4'hf, RESP_SLVERR);
      wr(A_ACCA_LO, 32'h1, 4'hf, RESP_SLVERR);
      wr(A_LIT, 32'hffff_ffff, 4'h1, RESP_OK);
      rck(A_LIT, 32'h0000_00ff);
   endtask
   task automatic t_mult();
      for (int i = 0; i < 6; i++) exec(5'(i), 1'b0);
      rck(8'h44, 32'h8000);
      rck(8'h94, 32'hbeef);
      exec(5'h06, 1'b0);
      rck(A_ACCA_LO, 32'h4000_0000);
      rck(A_STAT, 32'h0);
      exec(5'h07, 1'b0);
      rck(A_ACCA_LO, 32'h8000_0000);
      rck(A_STAT, 32'h6);
      exec(5'h08, 1'b0);
      rck(A_ACCB_LO, 32'h0001_8000);
      rck(A_STAT, 32'h6);
      exec(5'h09, 1'b0);
      rck(8'h58, 32'hbeef);
      rck(8'h74, 32'h8000);
      rck(A_STAT, 32'h6);
      exec(5'h0a, 1'b0);
      rck(A_ACCA_LO, 32'h4000_0000);
      rck(8'h74, 32'h0001);
      rck(A_STAT, 32'h0);
      exec(5'h0b, 1'b0);
      rck(A_ACCB_LO, 32'h9);
      rck(A_ACCB_HI, 32'h0);
   endtask
   task automatic t_moves();
      for (int i = 12; i < 17; i++) exec(5'(i), 1'b0);
      rck(8'h5c, 32'hbe45);
      rck(8'h60, 32'hbe45);
      rck(8'h40, 32'hbeef);
      rck(8'ha4, 32'hbeef);
      rck(8'h64, 32'hbeef);
      exec(5'h19, 1'b0);
      rck(8'ha4, 32'hbeef);
   endtask
   task automatic t_double();
      exec(5'h11, 1'b1);
      rck(8'ha8, 32'hbe45);
      rck(8'hac, 32'hbeef);
      pc <= 5'h12;
      @(posedge clk);
      wr(A_CMD, {11'h0, insn}, 4'hf, RESP_OK);
      // still busy: the second move cycle, pushed back by the peripheral stall, must refuse this
      wr(8'h40, 32'h5555, 4'hf, RESP_SLVERR);
      idle();
      rck(8'h40, 32'hbeef);
      rck(8'h78, 32'hbe45);
      rck(8'h7c, 32'hbeef);
   endtask
   task automatic t_pages();
      exec(5'h13, 1'b0);
      rck(A_PAGE, 32'h0000_03ff);
      exec(5'h14, 1'b0);
      rck(A_PAGE, 32'h0007_ffff);
      exec(5'h15, 1'b0);
      rck(A_PAGE, 32'h07ff_ffff);
      exec(5'h16, 1'b0);
      rck(A_PAGE, 32'h07ff_fe45);
      exec(5'h17, 1'b0);
      rck(A_PAGE, 32'h07f9_1645);
      exec(5'h18, 1'b1);
      rck(A_PAGE, 32'h0229_1645);
      rck(A_STAT, 32'h0);
   endtask
   //////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      {s_awvalid, s_wvalid, s_arvalid} = 3'h0;
      {s_bready, s_rready} = 2'h3;
      {s_awaddr, s_araddr, s_wdata, s_wstrb} = 52'h0;
      pc = 5'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_mult();
      t_moves();
      t_double();
      t_pages();
      stop_test();
   end
   // about twenty-six operations of a dozen or so cycles each fit well inside
   initial begin
      #200000;
      num_errors++;
      $display("CHECK FAILED t=%0t timeout", $time);
      stop_test();
   end
endmodule
